// ---- scpc_cfg.svh ----
`ifndef SCPC_CFG_SVH
`define SCPC_CFG_SVH

// register byte addresses, low address byte only
`define SCPC_ADDR_W        8
`define SCPC_ADDR_BUS_CFG  8'hDC
`define SCPC_ADDR_PWR_CTRL 8'hE0
`define SCPC_ADDR_IRQ_STAT 8'hE8
`define SCPC_ADDR_IRQ_MASK 8'hEC
`define SCPC_ADDR_FREE_RUN 8'hF4

// bus_arbitration_config fields
`define SCPC_WEIGHT_LSB    25
`define SCPC_BUS_RSV_BIT   27
`define SCPC_WEIGHT_RST    2'h0

// power_wake_control fields
`define SCPC_PHY_RESET_REQ_BIT   10
`define SCPC_LAN_EN_BIT    9
`define SCPC_ENERGY_WAKE_ENABLE_BIT     8
`define SCPC_CAUSE_LSB     3
`define SCPC_CAUSE_ED      0
`define SCPC_CAUSE_MAC     1

// interrupt status and mask fields
`define SCPC_IRQ_W         3
`define SCPC_IRQ_PHY_DONE  0
`define SCPC_IRQ_LAN_WAKE  1
`define SCPC_IRQ_ED_WAKE   2

// timing
`define SCPC_CLK_NS        100
`define SCPC_TICK_NS       160
`define SCPC_PHY_RESET_REQ_NS    100000
`define SCPC_PHY_RESET_REQ_CYC   ((`SCPC_PHY_RESET_REQ_NS + `SCPC_CLK_NS - 1) / `SCPC_CLK_NS)

`endif

// ---- scpc_pkg.sv ----
package scpc_pkg;

  // request or grant pair for the two dma engines
  typedef struct packed {
    logic rx;
    logic tx;
  } scpc_dma_t;

  // software-visible power control fields
  typedef struct packed {
    logic       phy_reset_req;
    logic       lan_en;
    logic       energy_wake_enable;
    logic [1:0] cause;
  } scpc_pwr_t;

  // timed phy reset sequencer
  typedef enum logic [1:0] {
    SCPC_PHY_IDLE = 2'b01,
    SCPC_PHY_HOLD = 2'b10
  } scpc_phy_state_t;

  // bus slave data phase tracker
  typedef enum logic [3:0] {
    SCPC_BUS_IDLE  = 4'b0001,
    SCPC_BUS_WRITE = 4'b0010,
    SCPC_BUS_RWAIT = 4'b0100,
    SCPC_BUS_RDATA = 4'b1000
  } scpc_bus_state_t;

endpackage

// ---- scpc_sys_ctrl.sv ----
// Summary of operation
// - weight field 00/01/10/11 gives rx:tx grant ratio 1:1, 2:1, 3:1, 4:1.
// - weight field acts only while the bus mode arbitration bit is zero.
// - writing one to phy reset bit holds phy reset at least 100 us.
// - phy reset bit clears itself when the phy leaves reset.
// - writes to phy reset bit are ignored while it reads one.
// - lan wake enable lets mac wake detect set pm event status.
// - energy wake enable lets phy interrupt set pm event status.
// - wake cause bit 3 marks energy detect, bit 4 mac wake, 00 none.
// - wake cause bits stay set until software writes one to them.
// - device reset returns the whole power control register to defaults.
// - 32-bit read-only counter, zero at reset, steps on average every 160 ns.
// - counter wraps from maximum to zero silently and keeps counting.
`timescale 1ns/1ns
`default_nettype none
`include "scpc_cfg.svh"

module scpc_sys_ctrl #(
  parameter int unsigned PHY_RESET_REQ_CYC = `SCPC_PHY_RESET_REQ_CYC,
  parameter int unsigned CNT_W       = 32
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  // ahb-lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic                hready,
  input  wire logic [31:0]         hwdata,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // dma arbitration
  input  wire logic                bus_arb_mode,
  input  wire logic                dma_slot,
  input  wire scpc_pkg::scpc_dma_t dma_req,
  output scpc_pkg::scpc_dma_t      dma_grant,
  // phy and wake pins
  output logic                     phy_reset_out,
  input  wire logic                mac_wake_det,
  input  wire logic                phy_irq,
  output logic                     pm_event_set,
  // interrupt
  output logic                     irq
);

  localparam int CW = $clog2(PHY_RESET_REQ_CYC + 1);

  // bus state
  scpc_pkg::scpc_bus_state_t  bus_state_reg;
  logic [`SCPC_ADDR_W-1:0]    bus_addr_reg;
  logic [31:0]                hrdata_reg;
  logic                       accept;
  logic                       wr_en;
  logic                       rd_cap;

  // register contents
  logic [1:0]                 arb_weight_sel_reg;
  logic                       bus_rsv_reg;
  scpc_pkg::scpc_pwr_t        pwr_reg;
  logic [`SCPC_IRQ_W-1:0]     irq_stat_reg;
  logic [`SCPC_IRQ_W-1:0]     irq_mask_reg;
  logic [`SCPC_IRQ_W-1:0]     irq_evt;

  // phy reset sequencer
  scpc_pkg::scpc_phy_state_t  phy_state_reg;
  logic [CW-1:0]              phy_cnt_reg;
  logic                       phy_start;
  logic                       phy_done;

  // wake inputs
  logic [1:0]                 wake_s1_reg;
  logic [1:0]                 wake_s2_reg;
  logic [1:0]                 wake_s3_reg;
  logic                       lan_evt;
  logic                       ed_evt;
  logic                       pm_event_set_reg;

  // free-running counter
  logic [8:0]                 tick_acc_reg;
  logic [8:0]                 tick_acc_next;
  logic                       tick_en;
  logic [CNT_W-1:0]           tick_counter_reg;

  // arbiter
  logic [2:0]                 rx_run_reg;
  logic                       rx_pick;

  // match the low address byte against a register address
  function automatic logic addr_is(input logic [`SCPC_ADDR_W-1:0] a,
                                   input logic [`SCPC_ADDR_W-1:0] r);
    addr_is = (a == r);
  endfunction

  // read data for one register address
  function automatic logic [31:0] rd_word(input logic [`SCPC_ADDR_W-1:0] a);
    rd_word = 32'h0000_0000;
    if (addr_is(a, `SCPC_ADDR_BUS_CFG)) begin
      rd_word[`SCPC_BUS_RSV_BIT] = bus_rsv_reg;
      rd_word[`SCPC_WEIGHT_LSB +: 2] = arb_weight_sel_reg;
    end
    if (addr_is(a, `SCPC_ADDR_PWR_CTRL)) begin
      rd_word[`SCPC_PHY_RESET_REQ_BIT] = pwr_reg.phy_reset_req;
      rd_word[`SCPC_LAN_EN_BIT] = pwr_reg.lan_en;
      rd_word[`SCPC_ENERGY_WAKE_ENABLE_BIT] = pwr_reg.energy_wake_enable;
      rd_word[`SCPC_CAUSE_LSB +: 2] = pwr_reg.cause;
    end
    if (addr_is(a, `SCPC_ADDR_IRQ_STAT)) begin
      rd_word[`SCPC_IRQ_W-1:0] = irq_stat_reg;
    end
    if (addr_is(a, `SCPC_ADDR_IRQ_MASK)) begin
      rd_word[`SCPC_IRQ_W-1:0] = irq_mask_reg;
    end
    if (addr_is(a, `SCPC_ADDR_FREE_RUN)) begin
      rd_word = 32'(tick_counter_reg);
    end
  endfunction

  // bus handshake: writes take no wait, reads take one wait state
  assign accept    = hsel && htrans[1] && hready;
  assign wr_en     = (bus_state_reg == scpc_pkg::SCPC_BUS_WRITE);
  assign rd_cap    = (bus_state_reg == scpc_pkg::SCPC_BUS_RWAIT);
  assign hreadyout = (bus_state_reg != scpc_pkg::SCPC_BUS_RWAIT);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  // data phase tracking
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bus_state_reg <= scpc_pkg::SCPC_BUS_IDLE;
      bus_addr_reg  <= '0;
    end else if (rd_cap) begin
      bus_state_reg <= scpc_pkg::SCPC_BUS_RDATA;
    end else if (accept) begin
      bus_addr_reg  <= haddr[`SCPC_ADDR_W-1:0];
      bus_state_reg <= hwrite ? scpc_pkg::SCPC_BUS_WRITE : scpc_pkg::SCPC_BUS_RWAIT;
    end else begin
      bus_state_reg <= scpc_pkg::SCPC_BUS_IDLE;
    end
  end

  // read data capture in the wait cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_cap) begin
      hrdata_reg <= rd_word(bus_addr_reg);
    end
  end

  // arbitration configuration register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      arb_weight_sel_reg <= `SCPC_WEIGHT_RST;
      bus_rsv_reg        <= 1'b0;
    end else if (wr_en && addr_is(bus_addr_reg, `SCPC_ADDR_BUS_CFG)) begin
      arb_weight_sel_reg <= hwdata[`SCPC_WEIGHT_LSB +: 2];
      bus_rsv_reg        <= hwdata[`SCPC_BUS_RSV_BIT];
    end
  end

  // power control enables and wake cause; reset clears all of it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pwr_reg.lan_en <= 1'b0;
      pwr_reg.energy_wake_enable  <= 1'b0;
      pwr_reg.cause  <= 2'h0;
    end else begin
      if (wr_en && addr_is(bus_addr_reg, `SCPC_ADDR_PWR_CTRL)) begin
        pwr_reg.lan_en <= hwdata[`SCPC_LAN_EN_BIT];
        pwr_reg.energy_wake_enable  <= hwdata[`SCPC_ENERGY_WAKE_ENABLE_BIT];
        pwr_reg.cause  <= (pwr_reg.cause & ~hwdata[`SCPC_CAUSE_LSB +: 2])
                          | {lan_evt, ed_evt};
      end else begin
        pwr_reg.cause[`SCPC_CAUSE_MAC] <= pwr_reg.cause[`SCPC_CAUSE_MAC] | lan_evt;
        pwr_reg.cause[`SCPC_CAUSE_ED]  <= pwr_reg.cause[`SCPC_CAUSE_ED] | ed_evt;
      end
    end
  end

  // phy reset request accepted only when idle
  assign phy_start = wr_en && addr_is(bus_addr_reg, `SCPC_ADDR_PWR_CTRL)
                     && hwdata[`SCPC_PHY_RESET_REQ_BIT]
                     && (phy_state_reg == scpc_pkg::SCPC_PHY_IDLE);
  assign phy_done  = (phy_state_reg == scpc_pkg::SCPC_PHY_HOLD)
                     && (phy_cnt_reg == CW'(PHY_RESET_REQ_CYC - 1));

  // timed phy reset sequencer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      phy_state_reg <= scpc_pkg::SCPC_PHY_IDLE;
      phy_cnt_reg   <= '0;
    end else begin
      unique case (phy_state_reg)
        scpc_pkg::SCPC_PHY_IDLE: begin
          phy_cnt_reg <= '0;
          if (phy_start) begin
            phy_state_reg <= scpc_pkg::SCPC_PHY_HOLD;
          end
        end
        scpc_pkg::SCPC_PHY_HOLD: begin
          phy_cnt_reg <= phy_cnt_reg + CW'(1);
          if (phy_done) begin
            phy_state_reg <= scpc_pkg::SCPC_PHY_IDLE;
          end
        end
      endcase
    end
  end

  // phy reset bit and pin follow the sequencer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pwr_reg.phy_reset_req <= 1'b0;
      phy_reset_out   <= 1'b0;
    end else begin
      pwr_reg.phy_reset_req <= phy_start || (pwr_reg.phy_reset_req && !phy_done);
      phy_reset_out   <= phy_start || (phy_reset_out && !phy_done);
    end
  end

  // two-stage synchronisers then one delay stage for edges
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wake_s1_reg <= 2'h0;
      wake_s2_reg <= 2'h0;
      wake_s3_reg <= 2'h0;
    end else begin
      wake_s1_reg <= {mac_wake_det, phy_irq};
      wake_s2_reg <= wake_s1_reg;
      wake_s3_reg <= wake_s2_reg;
    end
  end

  // enabled rising edges count as wake events
  assign lan_evt = pwr_reg.lan_en && wake_s2_reg[1] && !wake_s3_reg[1];
  assign ed_evt  = pwr_reg.energy_wake_enable && wake_s2_reg[0] && !wake_s3_reg[0];

  // pm event status set pulse
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pm_event_set_reg <= 1'b0;
    end else begin
      pm_event_set_reg <= lan_evt || ed_evt;
    end
  end

  assign pm_event_set = pm_event_set_reg;

  // interrupt events, sticky status cleared by read, set wins
  assign irq_evt = {ed_evt, lan_evt, phy_done};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_stat_reg <= '0;
    end else if (rd_cap && addr_is(bus_addr_reg, `SCPC_ADDR_IRQ_STAT)) begin
      irq_stat_reg <= irq_evt;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_evt;
    end
  end

  // interrupt mask
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_mask_reg <= '0;
    end else if (wr_en && addr_is(bus_addr_reg, `SCPC_ADDR_IRQ_MASK)) begin
      irq_mask_reg <= hwdata[`SCPC_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // fractional divider: average tick period of 160 ns from 100 ns clock
  assign tick_acc_next = tick_acc_reg + 9'(`SCPC_CLK_NS);
  assign tick_en       = (tick_acc_next >= 9'(`SCPC_TICK_NS));

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tick_acc_reg <= 9'h000;
    end else if (tick_en) begin
      tick_acc_reg <= tick_acc_next - 9'(`SCPC_TICK_NS);
    end else begin
      tick_acc_reg <= tick_acc_next;
    end
  end

  // free-running counter, wraps silently
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tick_counter_reg <= '0;
    end else if (tick_en) begin
      tick_counter_reg <= tick_counter_reg + CNT_W'(1);
    end
  end

  // rx wins while its run is within the weight; weight ignored in mode one
  always_comb begin
    rx_pick = 1'b1;
    if (dma_req.rx && dma_req.tx) begin
      if (!bus_arb_mode) begin
        rx_pick = (rx_run_reg <= {1'b0, arb_weight_sel_reg});
      end else begin
        rx_pick = (rx_run_reg == 3'h0);
      end
    end else begin
      rx_pick = dma_req.rx;
    end
  end

  // grants given only in a slot
  assign dma_grant.rx = dma_slot && dma_req.rx && rx_pick;
  assign dma_grant.tx = dma_slot && dma_req.tx && !rx_pick;

  // count consecutive rx grants since the last tx grant
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_run_reg <= 3'h0;
    end else if (dma_grant.tx) begin
      rx_run_reg <= 3'h0;
    end else if (dma_grant.rx && rx_run_reg != 3'h7) begin
      rx_run_reg <= rx_run_reg + 3'h1;
    end
  end

endmodule
`default_nettype wire

// ---- scpc_sys_ctrl_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module scpc_sys_ctrl_properties #(
  parameter int unsigned PHY_RESET_REQ_CYC = 8
) (
  // clock and reset
  input wire logic                clk,
  input wire logic                nrst,
  // arbitration
  input wire logic                bus_arb_mode,
  input wire logic                dma_slot,
  input wire scpc_pkg::scpc_dma_t dma_req,
  input wire scpc_pkg::scpc_dma_t dma_grant,
  // phy and wake
  input wire logic                phy_reset_out,
  input wire logic                mac_wake_det,
  input wire logic                phy_irq,
  input wire logic                pm_event_set,
  input wire logic                irq
);
  logic [15:0] hold_reg;
  logic [3:0]  age_reg;
  logic        both;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // both engines asking in a grant slot
  assign both = dma_slot && (dma_req == 2'b11);
  // length of the running phy reset pulse
  always_ff @(posedge clk) begin
    if (!nrst || !phy_reset_out) hold_reg <= 16'h0000;
    else hold_reg <= hold_reg + 16'h0001;
  end
  // cycles since the last wake pin rise, saturating
  always_ff @(posedge clk) begin
    if (!nrst) age_reg <= 4'hF;
    else if ($rose(mac_wake_det) || $rose(phy_irq)) age_reg <= 4'h0;
    else if (age_reg != 4'hF) age_reg <= age_reg + 4'h1;
  end
  // event strobe lasts one cycle
  sequence s_pulse;
    pm_event_set ##1 !pm_event_set;
  endsequence
  a_grant_onehot: assert property (dma_slot && |dma_req |-> $onehot(dma_grant))
    else $error("grant not one-hot");
  a_lone_rx: assert property (dma_slot && dma_req == 2'b10 |-> dma_grant == 2'b10)
    else $error("lone rx not granted");
  a_lone_tx: assert property (dma_slot && dma_req == 2'b01 |-> dma_grant == 2'b01)
    else $error("lone tx not granted");
  a_alt_mode: assert property (bus_arb_mode && both && $past(bus_arb_mode && both)
    |-> dma_grant != $past(dma_grant)) else $error("weight not ignored");
  a_phy_length: assert property ($fell(phy_reset_out) |-> hold_reg == 16'(PHY_RESET_REQ_CYC))
    else $error("phy reset pulse length");
  a_phy_bound: assert property (hold_reg <= 16'(PHY_RESET_REQ_CYC))
    else $error("phy reset pulse restarted");
  a_event_pulse: assert property (pm_event_set |-> s_pulse)
    else $error("event strobe too long");
  a_event_cause: assert property (pm_event_set |-> age_reg <= 4'h6)
    else $error("event without pin rise");
  a_reset_quiet: assert property ($rose(nrst) |-> !phy_reset_out && !irq && !pm_event_set)
    else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// ---- scpc_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module scpc_host (
  // clock and slave answer
  input wire logic   clk,
  input wire logic   hready,
  input wire logic [31:0] hrdata,
  // master request
  output logic        hsel,
  output logic [31:0] haddr,
  output logic [1:0]  htrans,
  output logic        hwrite,
  output logic [2:0]  hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
  end
  // one single word transfer; hready is sampled at each rising edge
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    // address phase stands until hready is seen high at an edge
    do @(posedge clk); while (!hready);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~a;
    hwdata <= w ? d : ~hwdata;
    // data phase stands until hready is seen high; read data taken at that edge
    do @(posedge clk); while (!hready);
    q = hrdata;
    hwdata <= ~hwdata; // released data does not hold its value
  endtask
endmodule
`default_nettype wire

// ---- tb_sys_ctrl_pm_counter_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "scpc_cfg.svh"
module tb_sys_ctrl_pm_counter_regs;
  localparam int unsigned PHY_RESET_REQ_CYC = 8;
  localparam logic [31:0] A_BUS = {24'h0, `SCPC_ADDR_BUS_CFG};
  localparam logic [31:0] A_PWR = {24'h0, `SCPC_ADDR_PWR_CTRL};
  localparam logic [31:0] A_STA = {24'h0, `SCPC_ADDR_IRQ_STAT};
  localparam logic [31:0] A_MSK = {24'h0, `SCPC_ADDR_IRQ_MASK};
  localparam logic [31:0] A_CNT = {24'h0, `SCPC_ADDR_FREE_RUN};
  logic clk, nrst, bus_arb_mode, dma_slot, mac_wake_det, phy_irq;
  wire logic hsel, hwrite, hreadyout, hresp, pm_event_set, irq, phy_reset_out;
  wire logic [31:0] haddr, hwdata, hrdata;
  wire logic [1:0] htrans;
  wire logic [2:0] hsize;
  scpc_pkg::scpc_dma_t dma_req;
  wire scpc_pkg::scpc_dma_t dma_grant;
  int miscompares, comparisons;
  logic [31:0] q, r1;
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  scpc_host i_host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  scpc_sys_ctrl #(.PHY_RESET_REQ_CYC(PHY_RESET_REQ_CYC)) i_dut (.clk(clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .bus_arb_mode(bus_arb_mode), .dma_slot(dma_slot), .dma_req(dma_req),
    .dma_grant(dma_grant), .phy_reset_out(phy_reset_out), .mac_wake_det(mac_wake_det),
    .phy_irq(phy_irq), .pm_event_set(pm_event_set), .irq(irq));
  // compare and bus tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task rd(input logic [31:0] a, input logic [31:0] exp);
    i_host.xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q);
  endtask
  // rx grants counted between two tx grants with both engines asking
  task arb(input logic [1:0] w, input logic m, input logic [3:0] e);
    logic [3:0] n, res;
    int t;
    wr(A_BUS, {5'h00, w, 25'h0});
    n = 4'h0; res = 4'hF; t = 0;
    @(posedge clk) begin bus_arb_mode <= m; dma_slot <= 1'b1; dma_req <= 2'b10; end
    @(posedge clk) dma_req <= 2'b01;
    @(posedge clk) dma_req <= 2'b11;
    repeat (16) begin
      @(negedge clk);
      if (dma_grant == 2'b10) n = n + 4'h1;
      else if (dma_grant == 2'b01) begin
        if (t == 1) res = n;
        t = t + 1; n = 4'h0;
      end
    end
    @(posedge clk) begin dma_slot <= 1'b0; dma_req <= 2'b00; end
    chk({28'h0, res}, {28'h0, e});
  endtask
  // one wake pin pulse, then irq is looked at
  task pin(input logic m, input logic exp_irq);
    @(posedge clk) if (m) mac_wake_det <= 1'b1; else phy_irq <= 1'b1;
    repeat (8) @(posedge clk);
    mac_wake_det <= 1'b0; phy_irq <= 1'b0;
    @(negedge clk) chk({31'h0, irq}, {31'h0, exp_irq});
  endtask
  task finish_test;
    if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    finish_test;
  end
  // main sequence
  initial begin
    nrst = 1'b0; bus_arb_mode = 1'b0; dma_slot = 1'b0; dma_req = 2'b00;
    mac_wake_det = 1'b0; phy_irq = 1'b0; miscompares = 0; comparisons = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd(A_BUS, 32'h0);
    rd(A_PWR, 32'h0);
    rd(A_STA, 32'h0);
    rd(32'h0, 32'h0);
    wr(A_BUS, 32'hFFFFFFFF);
    rd(A_BUS, 32'h0E000000);
    for (int w = 0; w < 4; w++) arb(w[1:0], 1'b0, 4'(w + 1));
    arb(2'h3, 1'b1, 4'h1);
    wr(A_PWR, 32'h400);
    rd(A_PWR, 32'h400);
    wr(A_PWR, 32'h400);
    repeat (8) @(posedge clk);
    rd(A_PWR, 32'h0);
    rd(A_STA, 32'h1);
    rd(A_STA, 32'h0);
    wr(A_MSK, 32'h7);
    wr(A_PWR, 32'h300);
    pin(1'b1, 1'b1);
    rd(A_PWR, 32'h310);
    rd(A_STA, 32'h2);
    chk({31'h0, irq}, 32'h0);
    wr(A_PWR, 32'h300);
    rd(A_PWR, 32'h310);
    wr(A_PWR, 32'h310);
    rd(A_PWR, 32'h300);
    wr(A_MSK, 32'h0);
    pin(1'b0, 1'b0);
    rd(A_PWR, 32'h308);
    rd(A_STA, 32'h4);
    wr(A_PWR, 32'h008);
    pin(1'b1, 1'b0);
    rd(A_PWR, 32'h0);
    i_host.xfer(1'b0, A_CNT, 32'h0, r1);
    repeat (76) @(posedge clk);
    i_host.xfer(1'b0, A_CNT, 32'h0, q);
    chk(q - r1, 32'h32);
    wr(A_CNT, 32'h0);
    @(posedge clk);
    rd(A_CNT, q + 32'h5);
    wr(A_PWR, 32'h300);
    nrst <= 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd(A_PWR, 32'h0);
    i_host.xfer(1'b0, A_CNT, 32'h0, q);
    chk(q, 32'h3);
    finish_test;
  end
endmodule
bind scpc_sys_ctrl scpc_sys_ctrl_properties #(.PHY_RESET_REQ_CYC(PHY_RESET_REQ_CYC)) i_props (
  .clk(clk), .nrst(nrst), .bus_arb_mode(bus_arb_mode), .dma_slot(dma_slot),
  .dma_req(dma_req), .dma_grant(dma_grant), .phy_reset_out(phy_reset_out),
  .mac_wake_det(mac_wake_det), .phy_irq(phy_irq), .pm_event_set(pm_event_set), .irq(irq));
`default_nettype wire
